// File: itfd_decoder.sv
// itfd_decoder: filters six input terminals and decodes them into drive commands
// assumes terminals synchronous to core_clk_i; codes set by the host stay legal and unique
`timescale 1ns/10ps

module itfd_decoder (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic [itfd_pkg::NUM_TERM-1:0] term_i,
    input wire logic [itfd_pkg::NUM_TERM*itfd_pkg::CODE_W-1:0] term_code_i,
    input wire logic [itfd_pkg::NUM_FAST-1:0] fast_pulse_mode_i,
    output logic [itfd_pkg::NUM_FAST-1:0] fast_pulse_input_o,
    output itfd_pkg::itfd_level_s level_cmd_o,
    output itfd_pkg::itfd_pulse_s pulse_cmd_o,
    output logic drive_block_o,
    output logic fault_latched_o,
    output logic channel_b_sel_o
);
    // synchroniser, filter and stable state
    logic [itfd_pkg::NUM_TERM-1:0] sync1_reg, sync1_next;
    logic [itfd_pkg::NUM_TERM-1:0] sync2_reg, sync2_next;
    logic [itfd_pkg::NUM_TERM-1:0] stable_reg, stable_next;
    logic [itfd_pkg::FILT_W-1:0] filt_cnt_reg [itfd_pkg::NUM_TERM];
    logic [itfd_pkg::FILT_W-1:0] filt_cnt_next [itfd_pkg::NUM_TERM];
    logic [itfd_pkg::NUM_TERM-1:0] rise;

    // digital role of each terminal; a fast terminal in pulse mode never decodes
    logic [itfd_pkg::NUM_TERM-1:0] digital_en;

    // filter: a level must persist for the filter time before it is accepted
    always_comb begin
        sync1_next = term_i;
        sync2_next = sync1_reg;
        stable_next = stable_reg;
        rise = '0;
        for (int t = 0; t < itfd_pkg::NUM_TERM; t++) begin
            filt_cnt_next[t] = itfd_pkg::FILT_RESET;
            if (sync2_reg[t] != stable_reg[t]) begin
                if (filt_cnt_reg[t] == itfd_pkg::FILT_LAST) begin
                    stable_next[t] = sync2_reg[t];
                    rise[t] = sync2_reg[t];
                end else begin
                    filt_cnt_next[t] = filt_cnt_reg[t] + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= itfd_pkg::TERM_RESET;
            sync2_reg <= itfd_pkg::TERM_RESET;
            stable_reg <= itfd_pkg::TERM_RESET;
            for (int t = 0; t < itfd_pkg::NUM_TERM; t++) begin
                filt_cnt_reg[t] <= itfd_pkg::FILT_RESET;
            end
        end else if (clk_en_i) begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            stable_reg <= stable_next;
            for (int t = 0; t < itfd_pkg::NUM_TERM; t++) begin
                filt_cnt_reg[t] <= filt_cnt_next[t];
            end
        end
    end

    // role of each terminal: general ones always digital, fast ones by mode
    always_comb begin
        digital_en = '1;
        for (int f = 0; f < itfd_pkg::NUM_FAST; f++) begin
            digital_en[itfd_pkg::NUM_GP+f] = ~fast_pulse_mode_i[f];
        end
    end

    // command decode
    itfd_pkg::itfd_level_s level_reg, level_next;
    itfd_pkg::itfd_pulse_s pulse_reg, pulse_next;
    logic [itfd_pkg::NUM_FAST-1:0] fast_pulse_reg, fast_pulse_next;
    logic block_reg, block_next;
    logic fault_reg, fault_next;
    logic chan_b_reg, chan_b_next;

    // decode every terminal; the host keeps codes unique so OR merging is safe
    always_comb begin
        logic [itfd_pkg::CODE_W-1:0] code;
        logic act;
        logic edg;
        code = '0;
        act = 1'b0;
        edg = 1'b0;
        level_next = itfd_pkg::LEVEL_RESET;
        pulse_next = itfd_pkg::PULSE_RESET;
        for (int t = 0; t < itfd_pkg::NUM_TERM; t++) begin
            code = term_code_i[t*itfd_pkg::CODE_W +: itfd_pkg::CODE_W];
            act = stable_reg[t] & digital_en[t];
            edg = rise[t] & digital_en[t];
            unique case (code)
                itfd_pkg::ITFD_FN_NONE: ;
                itfd_pkg::ITFD_FN_FWD_RUN: level_next.forward_run_cmd |= act;
                itfd_pkg::ITFD_FN_REV_RUN: level_next.reverse_run |= act;
                itfd_pkg::ITFD_FN_THREE_WIRE: level_next.three_wire |= act;
                itfd_pkg::ITFD_FN_FWD_JOG: level_next.forward_jog |= act;
                itfd_pkg::ITFD_FN_REV_JOG: level_next.reverse_jog |= act;
                itfd_pkg::ITFD_FN_COAST: level_next.coast_stop |= act;
                itfd_pkg::ITFD_FN_FAULT_RST: pulse_next.fault_reset |= edg;
                itfd_pkg::ITFD_FN_RUN_PAUSE: level_next.run_pause |= act;
                itfd_pkg::ITFD_FN_EXT_FAULT: pulse_next.ext_fault |= edg;
                itfd_pkg::ITFD_FN_FREQ_UP: level_next.freq_up |= act;
                itfd_pkg::ITFD_FN_FREQ_DOWN: level_next.freq_down |= act;
                itfd_pkg::ITFD_FN_UPDN_CLR: pulse_next.updn_clear |= edg;
                itfd_pkg::ITFD_FN_AB_SWITCH: pulse_next.ab_toggle |= edg;
                default: ; // codes 14 and 15 select no function and are ignored
            endcase
        end
    end

    // drive state: output block, latched fault, channel select
    always_comb begin
        fast_pulse_next = fast_pulse_mode_i;
        // coast blocks output at once; a fault also stops the drive
        block_next = level_next.coast_stop | fault_reg | pulse_next.ext_fault;
        fault_next = fault_reg;
        if (pulse_next.fault_reset) begin
            fault_next = 1'b0;
        end
        if (pulse_next.ext_fault) begin
            fault_next = 1'b1; // set wins over reset
        end
        chan_b_next = chan_b_reg ^ pulse_next.ab_toggle;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_reg <= itfd_pkg::LEVEL_RESET;
            pulse_reg <= itfd_pkg::PULSE_RESET;
            fast_pulse_reg <= itfd_pkg::FAST_PULSE_RESET;
            block_reg <= 1'b0;
            fault_reg <= 1'b0;
            chan_b_reg <= 1'b0;
        end else if (clk_en_i) begin
            level_reg <= level_next;
            pulse_reg <= pulse_next;
            fast_pulse_reg <= fast_pulse_next;
            block_reg <= block_next;
            fault_reg <= fault_next;
            chan_b_reg <= chan_b_next;
        end
    end

    assign level_cmd_o = level_reg;
    assign pulse_cmd_o = pulse_reg;
    assign fast_pulse_input_o = fast_pulse_reg;
    assign drive_block_o = block_reg;
    assign fault_latched_o = fault_reg;
    assign channel_b_sel_o = chan_b_reg;

    // checks: channel select, fault latch and output block
    ab_toggle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && pulse_next.ab_toggle |=> channel_b_sel_o != $past(channel_b_sel_o))
        else $error("channel select did not toggle");
    ab_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && pulse_next.ab_toggle |=> pulse_cmd_o.ab_toggle)
        else $error("channel switch pulse missing");
    fault_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && pulse_next.ext_fault |=> fault_latched_o && drive_block_o)
        else $error("external fault not latched");
    fault_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && pulse_next.fault_reset && !pulse_next.ext_fault |=> !fault_latched_o)
        else $error("fault reset ignored");
    reset_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && pulse_next.fault_reset |=> pulse_cmd_o.fault_reset)
        else $error("fault reset pulse missing");
    fault_block_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        fault_latched_o |-> drive_block_o)
        else $error("latched fault without output block");
    coast_block_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        level_cmd_o.coast_stop |-> drive_block_o)
        else $error("coast without output block");

    // checks: level commands follow the decoded level one edge later; all codes 0 decode to nothing
    fwd_run_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i |=> level_cmd_o.forward_run_cmd == $past(level_next.forward_run_cmd))
        else $error("forward run not forwarded");
    rev_run_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i |=> level_cmd_o.reverse_run == $past(level_next.reverse_run))
        else $error("reverse run not forwarded");
    three_wire_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i |=> level_cmd_o.three_wire == $past(level_next.three_wire))
        else $error("three-wire select not forwarded");
    fwd_jog_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i |=> level_cmd_o.forward_jog == $past(level_next.forward_jog))
        else $error("forward jog not forwarded");
    rev_jog_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i |=> level_cmd_o.reverse_jog == $past(level_next.reverse_jog))
        else $error("reverse jog not forwarded");
    pause_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && level_next.run_pause |=> level_cmd_o.run_pause)
        else $error("pause not forwarded");
    pause_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && !level_next.run_pause |=> !level_cmd_o.run_pause)
        else $error("pause not released");
    freq_up_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i |=> level_cmd_o.freq_up == $past(level_next.freq_up))
        else $error("frequency up not forwarded");
    freq_down_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i |=> level_cmd_o.freq_down == $past(level_next.freq_down))
        else $error("frequency down not forwarded");
    no_function_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && term_code_i == '0 |=> level_next == itfd_pkg::LEVEL_RESET
        && pulse_next == itfd_pkg::PULSE_RESET)
        else $error("code 0 terminal acted");

    // checks: clear pulse, filter, clock-enable freeze and pulse role
    single_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && pulse_cmd_o.updn_clear |=> !pulse_cmd_o.updn_clear)
        else $error("clear pulse repeated");
    clear_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && pulse_next.updn_clear |=> pulse_cmd_o.updn_clear)
        else $error("clear pulse missing");
    filter_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && rise[0] |-> $past(sync2_reg[0], 2) || !clk_en_i)
        else $error("accepted edge not held");
    filter_bound_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        filt_cnt_reg[0] <= itfd_pkg::FILT_LAST)
        else $error("filter counter overran");
    filter_restart_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && sync2_reg[0] == stable_reg[0] |=> filt_cnt_reg[0] == itfd_pkg::FILT_RESET)
        else $error("filter counter not restarted");
    freeze_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !clk_en_i |=> $stable(level_cmd_o) && $stable(fault_latched_o) && $stable(channel_b_sel_o))
        else $error("state moved while frozen");
    pulse_mode_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && fast_pulse_mode_i[0] && rise[itfd_pkg::NUM_GP]
        && term_code_i[itfd_pkg::NUM_GP*itfd_pkg::CODE_W +: itfd_pkg::CODE_W] == 4'h7
        |-> !pulse_next.fault_reset)
        else $error("pulse-mode terminal decoded");
    pulse_role_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clk_en_i |=> fast_pulse_input_o == $past(fast_pulse_mode_i))
        else $error("pulse role flags not reported");
endmodule : itfd_decoder

// File: itfd_pkg.sv
// itfd_pkg: constants and carriers for the input terminal function decoder
// assumes a single 40 MHz core clock and terminal inputs synchronous to it
package itfd_pkg;
    localparam int unsigned NUM_GP = 4;
    localparam int unsigned NUM_FAST = 2;
    localparam int unsigned NUM_TERM = NUM_GP + NUM_FAST;
    localparam int unsigned CODE_W = 4;
    // clock figures
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned FILT_TIME_NS = 1000;
    localparam int unsigned FILT_CYCLES = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FILT_W = 6;
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYCLES - 1);
    localparam logic [FILT_W-1:0] FILT_RESET = 6'h00;
    localparam logic [NUM_TERM-1:0] TERM_RESET = 6'h00;
    localparam logic [NUM_FAST-1:0] FAST_PULSE_RESET = 2'h0;

    typedef enum logic [3:0] {
        ITFD_FN_NONE      = 4'h0,
        ITFD_FN_FWD_RUN   = 4'h1,
        ITFD_FN_REV_RUN   = 4'h2,
        ITFD_FN_THREE_WIRE = 4'h3,
        ITFD_FN_FWD_JOG   = 4'h4,
        ITFD_FN_REV_JOG   = 4'h5,
        ITFD_FN_COAST     = 4'h6,
        ITFD_FN_FAULT_RST = 4'h7,
        ITFD_FN_RUN_PAUSE = 4'h8,
        ITFD_FN_EXT_FAULT = 4'h9,
        ITFD_FN_FREQ_UP   = 4'ha,
        ITFD_FN_FREQ_DOWN = 4'hb,
        ITFD_FN_UPDN_CLR  = 4'hc,
        ITFD_FN_AB_SWITCH = 4'hd
    } itfd_func_e;

    // level commands held while the terminal is active
    typedef struct packed {
        logic forward_run_cmd;
        logic reverse_run;
        logic three_wire;
        logic forward_jog;
        logic reverse_jog;
        logic coast_stop;
        logic run_pause;
        logic freq_up;
        logic freq_down;
    } itfd_level_s;

    // one-cycle pulses on the activating edge
    typedef struct packed {
        logic fault_reset;
        logic ext_fault;
        logic updn_clear;
        logic ab_toggle;
    } itfd_pulse_s;

    localparam itfd_level_s LEVEL_RESET = '0;
    localparam itfd_pulse_s PULSE_RESET = '0;
endpackage : itfd_pkg

// File: itfd_switch_model.sv
// itfd_switch_model: external switches or controller wired to the six terminals
// assumes the bench commands contact levels and any bounce on the core clock
`timescale 1ns/10ps
module itfd_switch_model (
    input wire logic [5:0] level_i,
    input wire logic [5:0] bounce_i,
    output logic [5:0] term_o
);
    // bounce flips a contact for a short burst, as a real switch does
    assign term_o = level_i ^ bounce_i;
endmodule : itfd_switch_model

// File: testbench.sv
// testbench: random terminal and mode choice, codes taken in order, every function code exercised
// assumes the decoder's fixed 40-cycle filter and a 40 MHz clock
`timescale 1ns/10ps
module testbench;
    logic core_clk_i, rst_i, clk_en_i;
    logic [5:0] lvl, bnc, term_w;
    logic [1:0] fmode, fast_o;
    logic [23:0] codes;
    itfd_pkg::itfd_level_s lvl_o;
    itfd_pkg::itfd_pulse_s pls_o, pseen;
    logic blk_o, flt_o, chb_o, exp_flt, exp_chb;
    logic [16:0] seed;
    int err_count, num_checks, pcnt;

    itfd_switch_model sw_u (.level_i(lvl), .bounce_i(bnc), .term_o(term_w));
    itfd_decoder dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .term_i(term_w),
        .term_code_i(codes), .fast_pulse_mode_i(fmode), .fast_pulse_input_o(fast_o),
        .level_cmd_o(lvl_o), .pulse_cmd_o(pls_o), .drive_block_o(blk_o),
        .fault_latched_o(flt_o), .channel_b_sel_o(chb_o));

    // pulses stand one cycle, so count and collect them on every falling edge
    always @(negedge core_clk_i) begin
        if (pls_o !== 4'h0) begin
            pcnt++;
            pseen = pseen | pls_o;
        end
    end

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        lfsr = {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr

    function automatic logic [8:0] exp_lvl(input logic [3:0] c);
        case (c)
            4'h1: exp_lvl = 9'h100;
            4'h2: exp_lvl = 9'h080;
            4'h3: exp_lvl = 9'h040;
            4'h4: exp_lvl = 9'h020;
            4'h5: exp_lvl = 9'h010;
            4'h6: exp_lvl = 9'h008;
            4'h8: exp_lvl = 9'h004;
            4'ha: exp_lvl = 9'h002;
            4'hb: exp_lvl = 9'h001;
            default: exp_lvl = 9'h000;
        endcase
    endfunction : exp_lvl

    function automatic logic [3:0] exp_pls(input logic [3:0] c);
        case (c)
            4'h7: exp_pls = 4'h8;
            4'h9: exp_pls = 4'h4;
            4'hc: exp_pls = 4'h2;
            4'hd: exp_pls = 4'h1;
            default: exp_pls = 4'h0;
        endcase
    endfunction : exp_pls

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // one terminal alone carries code c, so codes never repeat
    task automatic press(input int t, input logic [3:0] c, input logic [1:0] fm);
        logic [23:0] cv;
        logic on;
        int p0;
        cv = 24'h0;
        cv[t*4 +: 4] = c;
        on = !(t >= 4 && fm[t-4]);
        @(posedge core_clk_i);
        codes <= cv;
        fmode <= fm;
        repeat (3) @(posedge core_clk_i);
        check(fast_o, fm);
        p0 = pcnt;
        pseen = 4'h0;
        lvl <= 6'h01 << t;
        repeat (48) @(posedge core_clk_i);
        if (on && c == 4'h9) exp_flt = 1'b1;
        if (on && c == 4'h7) exp_flt = 1'b0;
        if (on && c == 4'hd) exp_chb = ~exp_chb;
        check(lvl_o, on ? exp_lvl(c) : 9'h000);
        check(pseen, on ? exp_pls(c) : 4'h0);
        check(pcnt - p0, (on && exp_pls(c) != 4'h0) ? 1 : 0);
        check({blk_o, flt_o, chb_o}, {exp_flt | (on && c == 4'h6), exp_flt, exp_chb});
        lvl <= 6'h00;
        repeat (48) @(posedge core_clk_i);
        check({lvl_o, blk_o, pcnt - p0 > 1}, {9'h000, exp_flt, 1'b0});
    endtask : press

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    initial begin
        #500000;
        err_count++;
        test_done();
    end

    initial begin
        rst_i = 1'b1;
        clk_en_i = 1'b1;
        lvl = 6'h00;
        bnc = 6'h00;
        fmode = 2'h0;
        codes = 24'h0;
        pcnt = 0;
        pseen = 4'h0;
        exp_flt = 1'b0;
        exp_chb = 1'b0;
        seed = 17'd76792;
        err_count = 0;
        num_checks = 0;
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        check({lvl_o, pls_o, blk_o, flt_o, chb_o, fast_o}, 18'h0);
        // two passes over every code, including the unused 14 and 15
        for (int n = 0; n < 32; n++) begin
            seed = lfsr(seed);
            press(seed % 6, n[3:0], seed[9:8]);
        end
        press(1, 4'h7, 2'h0);
        press(0, 4'h1, 2'h0);
        // a 20-cycle bounce is shorter than the filter and must vanish
        bnc <= 6'h01;
        repeat (20) @(posedge core_clk_i);
        bnc <= 6'h00;
        repeat (48) @(posedge core_clk_i);
        check(lvl_o, 9'h000);
        // a frozen clock enable must hold off even a long press
        clk_en_i <= 1'b0;
        lvl <= 6'h01;
        repeat (60) @(posedge core_clk_i);
        check(lvl_o, 9'h000);
        clk_en_i <= 1'b1;
        repeat (48) @(posedge core_clk_i);
        check(lvl_o, 9'h100);
        lvl <= 6'h00;
        repeat (48) @(posedge core_clk_i);
        check(lvl_o, 9'h000);
        test_done();
    end
endmodule : testbench
